// file: bench/cdl_ui_model.sv
/*
 User-interface partner of the coded door lock core: digit flag, digit
 value and the two command levels. Assumes the caller runs in aclk time.
*/
`timescale 1ns/1ps
module cdl_ui_model (
    // clock
    input wire logic aclk,
    // digits and commands towards the lock
    output cdl_pkg::cdl_ui_t ui
);
    import cdl_pkg::*;

    // idle: no flag, no commands
    initial ui = '{digit_flag: 1'b0, digit_value: 8'hFF, change_req: 1'b0, lock_req: 1'b0};

    // one digit per single-cycle flag, value qualified only by the flag
    task automatic send_digit(input logic [7:0] d);
        @(posedge aclk);
        ui.digit_flag <= 1'b1;
        ui.digit_value <= d;
        @(posedge aclk);
        ui.digit_flag <= 1'b0;
        // unqualified value must not look held, so show its inverse
        ui.digit_value <= ~d;
    endtask

    // command levels, changed just after an edge
    task automatic set_req(input logic lock, input logic change);
        @(posedge aclk);
        ui.lock_req <= lock;
        ui.change_req <= change;
    endtask
endmodule

// file: bench/coded_door_lock_core_test.sv
/*
 Self-checking bench of the coded door lock core: AXI4-Lite master tasks,
 integer model of sequencer, digit counter and stored secret, user-interface
 partner. Assumes the secret slots power up holding the blank code.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module coded_door_lock_core_test;
    import cdl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, door_open;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rsp;
    cdl_ui_t ui;
    cdl_state_t mode;
    int error_cnt = 0, comparisons = 0, seed = 79, m_state = 0, m_rank = 0, m_en = 1;
    int entered[$], secret[$];

    cdl_core #(.NUM_DIGITS(CODE_DIGITS)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .ui(ui), .door_open(door_open), .mode(mode));
    cdl_ui_model u_ui (.aclk(aclk), .ui(ui));

    // 100 MHz clock
    initial forever #5 aclk = ~aclk;

    // hang guard, well beyond the whole sequence
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        complete_run();
    end

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // write: address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done = 0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    // model of one flagged digit: verdict or new secret on the last one
    task automatic model_digit(input int d);
        bit match;
        if (m_en == 0 || m_state == 2) return;
        if (m_state == 0) m_state = 1;
        entered.push_back(d);
        m_rank = (m_rank + 1) % CODE_DIGITS;
        if (m_rank == 0) begin
            match = 1'b1;
            foreach (entered[i]) if (entered[i] != secret[i]) match = 1'b0;
            if (m_state == 3) secret = entered;
            m_state = (m_state == 3 || match) ? 2 : 0;
            entered.delete();
        end
    endtask

    task automatic digit(input int d);
        u_ui.send_digit(d[7:0]);
        model_digit(d);
    endtask

    // one-cycle command pulse on the pins; only an open door listens
    task automatic request(input bit lock, input bit change);
        u_ui.set_req(lock, change);
        u_ui.set_req(1'b0, 1'b0);
        if (m_state == 2 && lock) m_state = 0;
        else if (m_state == 2 && change) m_state = 3;
    endtask

    // the stored code, digit by digit, checked after each
    task automatic enter_secret();
        int code[$];
        code = secret;
        foreach (code[k]) begin
            digit(code[k]);
            check_state();
        end
    endtask

    // ports and status word against the model
    task automatic check_state();
        #1;
        `CHK(mode, cdl_state_t'(m_state[1:0]))
        `CHK(door_open, 1'(m_state == 2))
        axi_read(STATUS_ADDR, rd, rsp);
        `CHK(rd, {27'h0, m_state[1:0], m_rank[1:0], 1'(m_state == 2)})
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        m_state = 0;
        m_rank = 0;
        m_en = 1;
        entered.delete();
    endtask

    initial begin
        repeat (CODE_DIGITS) secret.push_back(int'(SECRET_BLANK));
        do_reset();
        check_state();
        axi_read(CTRL_ADDR, rd, rsp);
        `CHK(rd, 32'h1)
        // unmapped place: refused both ways
        axi_read(4'h8, rd, rsp);
        `CHK({rd, rsp}, {32'h0, RESP_SLVERR})
        axi_write(4'hC, 32'hFFFF_FFFF, rsp);
        `CHK(rsp, RESP_SLVERR)
        // blank secret opens; an open door ignores digits; store a new secret
        enter_secret();
        digit(7);
        check_state();
        request(1'b0, 1'b1);
        check_state();
        for (int k = 0; k < CODE_DIGITS; k++) begin
            digit({$random(seed)} % 10);
            check_state();
        end
        request(1'b1, 1'b1);
        check_state();
        // random codes, state and rank after every digit
        repeat (6) begin
            for (int k = 0; k < CODE_DIGITS; k++) begin
                digit({$random(seed)} % 10);
                check_state();
            end
        end
        // back-to-back code
        for (int k = 0; k < CODE_DIGITS; k++) digit({$random(seed)} % 10);
        check_state();
        // lock and change are refused outside the unlocked state
        digit(9);
        request(1'b1, 1'b1);
        axi_write(CTRL_ADDR, 32'h3, rsp);
        if (m_state == 2) m_state = 0;
        `CHK(rsp, RESP_OKAY)
        check_state();
        axi_read(CTRL_ADDR, rd, rsp);
        `CHK(rd, 32'h1)
        digit(0);
        digit(9);
        check_state();
        // entry disabled: digits are ignored
        axi_write(CTRL_ADDR, 32'h0, rsp);
        m_en = 0;
        digit(5);
        check_state();
        // a second reset mid-code clears the sequence and control
        m_en = 1;
        axi_write(CTRL_ADDR, 32'h1, rsp);
        digit(1);
        check_state();
        axi_write(CTRL_ADDR, 32'h0, rsp);
        do_reset();
        check_state();
        axi_read(CTRL_ADDR, rd, rsp);
        `CHK(rd, 32'h1)
        // secret outlives reset; software lock closes the door again
        enter_secret();
        axi_write(CTRL_ADDR, 32'h3, rsp);
        if (m_state == 2) m_state = 0;
        check_state();
        complete_run();
    end
endmodule

// file: core/cdl_core.sv
/*
 Coded door lock core: sequencer, digit counter, secret and entered
 digit slots, comparator and an AXI4-Lite register slave.
 Assumes user-interface inputs synchronous to aclk, one flag per digit.
*/
`timescale 1ns/1ps
module cdl_core #(
    parameter int NUM_DIGITS = cdl_pkg::CODE_DIGITS
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [cdl_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [cdl_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // user interface
    input wire cdl_pkg::cdl_ui_t ui,
    // lock side
    output logic door_open,
    output cdl_pkg::cdl_state_t mode
);
    import cdl_pkg::*;

    // the rank counter must be able to name every slot
    if (NUM_DIGITS < 2 || NUM_DIGITS > (1 << RANK_W)) begin : g_bad_digits
        $error("NUM_DIGITS out of range");
    end

    localparam logic [RANK_W-1:0] RANK_FIRST = '0;
    localparam logic [RANK_W-1:0] RANK_ONE = RANK_W'(1);
    localparam logic [RANK_W-1:0] RANK_LAST = RANK_W'(NUM_DIGITS - 1);

    // true when the counter points at slot idx
    function automatic logic rank_hit(input logic [RANK_W-1:0] r, input int idx);
        rank_hit = (r == RANK_W'(idx));
    endfunction

    // only the two documented words answer OKAY
    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        reg_known = (a == CTRL_ADDR) || (a == STATUS_ADDR);
    endfunction

    cdl_state_t state;
    cdl_state_t next_state;
    logic [RANK_W-1:0] rank;
    logic [RANK_W-1:0] next_rank;
    // secret slots start from a known blank code; without it the first
    // verdict would be unknown and nobody could ever reach secret entry
    logic [NUM_DIGITS-1:0][DIGIT_W-1:0] nv_slot = {NUM_DIGITS{SECRET_BLANK}};
    logic [NUM_DIGITS-1:0][DIGIT_W-1:0] ram_slot;
    logic [NUM_DIGITS-1:0] nv_we;
    logic [NUM_DIGITS-1:0] ram_we;
    logic [NUM_DIGITS-1:0] slot_eq;
    logic entry_en;
    logic sw_lock;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // internal conditions of the sequencer
    wire in_secret = (state == CDL_SECRET);
    wire accept = ui.digit_flag && entry_en && (state != CDL_OPEN);
    wire first_digit = accept && (rank == RANK_FIRST);
    wire last_digit = accept && (rank == RANK_LAST);
    wire code_right = &slot_eq;
    wire lock_cmd = ui.lock_req || sw_lock;

    // slot strobes; the last entered digit is compared straight off
    // the input so the verdict lands on the same edge as the digit
    for (genvar i = 0; i < NUM_DIGITS; i++) begin : g_slot
        assign nv_we[i] = accept && in_secret && rank_hit(rank, i);
        assign ram_we[i] = accept && !in_secret && rank_hit(rank, i);
        if (i == NUM_DIGITS - 1) begin : g_live
            assign slot_eq[i] = (nv_slot[i] == ui.digit_value);
        end else begin : g_held
            assign slot_eq[i] = (nv_slot[i] == ram_slot[i]);
        end
    end

    // secret slots have no reset so the code outlives a reset;
    // real retention across power loss needs a non-volatile macro here
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_DIGITS; i++) begin
            if (nv_we[i]) begin
                nv_slot[i] <= ui.digit_value;
            end
        end
    end

    // entered digits, volatile
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_slot <= '0;
        end else begin
            for (int i = 0; i < NUM_DIGITS; i++) begin
                if (ram_we[i]) begin
                    ram_slot[i] <= ui.digit_value;
                end
            end
        end
    end

    // digit counter: wraps to the first slot on the last digit
    assign next_rank = last_digit ? RANK_FIRST : (accept ? rank + RANK_ONE : rank);

    // sequencer; lock wins over change when both come together
    always_comb begin
        next_state = state;
        case (state)
            CDL_LOCKED: begin
                if (first_digit) begin
                    next_state = CDL_RECOG;
                end
            end
            CDL_RECOG: begin
                if (last_digit) begin
                    next_state = code_right ? CDL_OPEN : CDL_LOCKED;
                end
            end
            CDL_OPEN: begin
                if (lock_cmd) begin
                    next_state = CDL_LOCKED;
                end else if (ui.change_req) begin
                    next_state = CDL_SECRET;
                end
            end
            CDL_SECRET: begin
                if (last_digit) begin
                    next_state = CDL_OPEN;
                end
            end
            default: begin
                next_state = CDL_LOCKED;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= CDL_LOCKED;
            rank <= RANK_FIRST;
            door_open <= 1'b0;
        end else begin
            state <= next_state;
            rank <= next_rank;
            door_open <= (next_state == CDL_OPEN);
        end
    end

    assign mode = state;

    // bus slave: address and data are held separately, any order
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire wr_go = aw_held && w_held && !bvalid;
    wire ar_take = arvalid && arready;
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // read mux; the stored secret is never readable
    wire cdl_status_t status_now = '{state: state, rank: rank, door_open: door_open};
    wire [31:0] ctrl_word = 32'(entry_en) << CTRL_EN_BIT;
    wire [31:0] status_word = 32'(status_now);
    wire [31:0] read_word = (araddr == CTRL_ADDR) ? ctrl_word :
                            (araddr == STATUS_ADDR) ? status_word : 32'h0000_0000;
    wire ctrl_wr = wr_go && (wr_addr == CTRL_ADDR) && wr_strb[0];

    // write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response and control register; lock bit is a pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            entry_en <= CTRL_EN_RESET;
            sw_lock <= 1'b0;
        end else begin
            sw_lock <= ctrl_wr && wr_data[CTRL_LOCK_BIT];
            if (ctrl_wr) begin
                entry_en <= wr_data[CTRL_EN_BIT];
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start;
        state == CDL_LOCKED && accept;
    endsequence

    sequence s_verdict_ok;
        state == CDL_RECOG && last_digit && code_right;
    endsequence

    sequence s_verdict_bad;
        state == CDL_RECOG && last_digit && !code_right;
    endsequence

    sequence s_secret_last;
        state == CDL_SECRET && last_digit;
    endsequence

    start_recog_a: assert property (s_start |=> state == CDL_RECOG)
        else $error("first digit did not start recognition");

    right_opens_a: assert property (s_verdict_ok |=> state == CDL_OPEN && door_open)
        else $error("right code did not unlock");

    wrong_relocks_a: assert property (s_verdict_bad |=> state == CDL_LOCKED && !door_open)
        else $error("wrong code did not relock");

    lock_wins_a: assert property (state == CDL_OPEN && lock_cmd |=> state == CDL_LOCKED)
        else $error("lock request ignored while unlocked");

    change_enters_a: assert property (
        state == CDL_OPEN && !lock_cmd && ui.change_req |=> state == CDL_SECRET && rank == '0)
        else $error("change request did not enter secret entry");

    secret_ends_a: assert property (s_secret_last |=> state == CDL_OPEN)
        else $error("third secret digit did not end entry");

    rank_wraps_a: assert property (last_digit |=> rank == RANK_FIRST)
        else $error("digit counter did not wrap");

    rank_steps_a: assert property (
        accept && !last_digit |=> rank == $past(rank) + RANK_ONE)
        else $error("digit counter did not advance");

    secret_load_a: assert property (
        in_secret && accept && rank == RANK_FIRST |=> nv_slot[0] == $past(ui.digit_value))
        else $error("secret slot not loaded");

    secret_hold_a: assert property (!in_secret |=> $stable(nv_slot))
        else $error("secret slot changed outside entry");

    entered_load_a: assert property (
        !in_secret && accept && rank == RANK_ONE |=> ram_slot[1] == $past(ui.digit_value))
        else $error("entered digit not stored");

    entered_hold_a: assert property (in_secret |=> $stable(ram_slot))
        else $error("entered slots written during secret entry");

    open_only_match_a: assert property ($rose(door_open) |-> $past(in_secret) ||
        $past(state == CDL_RECOG && code_right))
        else $error("door opened without a matching code");

    bvalid_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    rvalid_holds_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");

    write_answer_a: assert property (aw_held && w_held && !bvalid |=> bvalid)
        else $error("write not answered one cycle after capture");

    // digits and commands that the current state must refuse, then the load of the last secret slot
    open_deaf_a: assert property (state == CDL_OPEN && ui.digit_flag |=>
        $stable(rank) && $stable(ram_slot))
        else $error("digit taken while unlocked");

    entry_off_a: assert property (ui.digit_flag && !entry_en && state != CDL_OPEN |=>
        $stable(rank) && $stable(state))
        else $error("digit taken while entry disabled");

    locked_stays_a: assert property (state == CDL_LOCKED && !accept |=> state == CDL_LOCKED)
        else $error("locked state left without a digit");

    recog_stays_a: assert property (state == CDL_RECOG && !last_digit |=> state == CDL_RECOG)
        else $error("recognition left before the last digit");

    secret_last_a: assert property (s_secret_last |=>
        nv_slot[NUM_DIGITS-1] == $past(ui.digit_value))
        else $error("last secret slot not loaded");

endmodule

// file: core/cdl_pkg.sv
/*
 Constants, state codes and carrier types of the coded door lock core.
 Assumes one 100 MHz clock and a user interface that announces digits.
*/
package cdl_pkg;
    // code shape
    localparam int CODE_DIGITS = 3;
    localparam int RANK_W = 2;
    localparam int DIGIT_W = 8;
    // power-up content of each secret slot, a plain default
    localparam logic [DIGIT_W-1:0] SECRET_BLANK = 8'h00;
    // register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LOCK_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'h1;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CDL_LOCKED = 2'b00,
        CDL_RECOG = 2'b01,
        CDL_OPEN = 2'b10,
        CDL_SECRET = 2'b11
    } cdl_state_t;

    // user-interface inputs
    typedef struct packed {
        logic digit_flag;
        logic [DIGIT_W-1:0] digit_value;
        logic change_req;
        logic lock_req;
    } cdl_ui_t;

    // status word, low bits of the status register
    typedef struct packed {
        cdl_state_t state;
        logic [RANK_W-1:0] rank;
        logic door_open;
    } cdl_status_t;
endpackage
